/* design/gpmx_port.sv */
/*
  gpmx_port: one general-purpose port; apb slave holding the pin mux,
  direction, pull and data registers, and the per-pin pad drive.
  assumes: apb master in the same CORE_CLK domain, pins synchronous,
  alternate functions supply their own output, output enable and
  open-drain need; IS_PORT_C/PKG_64 straps are static.
*/
`timescale 1ns/10ps
`default_nettype none

// Function
// - low mux register holds pins 0-7 select fields at bits 4x+2:4x.
// - high mux register holds pins 8-15 select fields at bits 4(x-8)+2:4(x-8).
// - codes 000-100 select functions zero-four, 111 selects seven; 101/110 reserved.
// - alternate function sets the pin direction the function needs.
// - functions one-seven ignore direction register; function zero obeys it.
// - port C pins twelve, thirteen mux locked while fast oscillator clocks the core.
// - mux, direction and pull registers write only while unlock gate active.
// - direction register holds 2-bit field per pin at bits 2x+1:2x.
// - direction 00 push-pull, 01 open-drain, 1x input.
// - port C pins seven, eight drive open-drain only.
// - mux reset values depend on port and package.
// - direction register resets to all ones, every pin input.
// - each port sits in its own 0x100-spaced block.
// - input data read-only at 0x34, output data read/write at 0x30.
// - write-only bit set/reset at 0x38 and bit clear at 0x3C.
// - interrupt status is write-one-to-clear, beside enable and control.
// - unlock register at 0x1FF0 resets to zero, mux, direction and pull protected.
module gpmx_port
  import gpmx_pkg::*;
#(
  parameter logic [31:0] RST_MUX_LOW_P  = gpmx_pkg::RST_MUX_LOW,
  parameter logic [31:0] RST_MUX_HIGH_P = gpmx_pkg::RST_MUX_HIGH,
  parameter logic [31:0] RST_DIR_P      = gpmx_pkg::RST_DIRECTION,
  parameter logic [31:0] RST_PULL_P     = gpmx_pkg::RST_PULL,
  parameter bit          IS_PORT_C      = 1'b0,
  parameter bit          PKG_64         = 1'b1
) (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        CLK_EN,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [12:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // system status
  input  wire logic        EXT_FAST_OSC_IS_MAIN,
  // pins
  input  wire logic [15:0] PIN_IN,
  output logic      [15:0] PIN_OUT,
  output logic      [15:0] PIN_OE,
  // alternate functions
  input  wire logic [15:0] ALT_OUT,
  input  wire logic [15:0] ALT_OE,
  input  wire logic [15:0] ALT_OPEN_DRAIN,
  input  wire logic [15:0] IRQ_EVENT,
  // configuration seen by pads and peripherals
  output logic      [47:0] PIN_FUNCTION_SELECT,
  output logic      [31:0] PULL_CTRL,
  output logic      [15:0] DEBOUNCE_EN,
  output logic      [15:0] STRENGTH_EN,
  output logic      [31:0] IRQ_ENABLE,
  output logic      [31:0] IRQ_CONTROL
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] mux_lo;
    logic [31:0] mux_hi;
    logic [31:0] dir;
    logic [31:0] pull;
    logic [15:0] deb;
    logic [15:0] str;
    logic [31:0] ien;
    logic [31:0] ist;
    logic [31:0] ictl;
    logic [15:0] odr;
    logic [15:0] idr;
    logic        unlock;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic [15:0] pout;
    logic [15:0] poe;
  } gpmx_state_t;

  // ----------------------------------------------------------------
  // per-pin decode
  // ----------------------------------------------------------------
  // reset of port C low mux follows the package strap
  localparam logic [31:0] MUX_LO_INIT =
    IS_PORT_C ? (PKG_64 ? RST_PC_LOW_64 : RST_PC_LOW_48) : RST_MUX_LOW_P;

  gpmx_state_t s_q;
  gpmx_state_t s_d;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [31:0] mux_lo_wr;
  logic [31:0] mux_hi_wr;

  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && PENABLE && !PWRITE;

  always_comb begin
    case (PADDR)
      OFS_MUX_LOW, OFS_MUX_HIGH, OFS_DIRECTION, OFS_PULL, OFS_DEBOUNCE,
      OFS_STRENGTH, OFS_IRQ_EN, OFS_IRQ_STAT, OFS_IRQ_CTRL, OFS_OUT_DATA,
      OFS_IN_DATA, OFS_BIT_SETRST, OFS_BIT_CLEAR, OFS_UNLOCK: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // merge a mux write field by field; reserved codes and locked pins keep old value
  // the oscillator flag comes in as an argument so that the assigns below
  // wake up when it changes, not only when the bus data changes
  function automatic logic [31:0] mux_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input int          first_pin,
                                             input logic        osc_main);
    logic [31:0] r;
    logic [2:0]  code;
    int          pin;
    r = old_v & MUX_USED_MASK;
    for (int i = 0; i < 8; i++) begin
      code = new_v[i*MUX_PITCH +: MUX_W];
      pin  = first_pin + i;
      if ((code <= FUNC_FOUR || code == FUNC_SEVEN)
          && !(IS_PORT_C && osc_main
               && (pin == PC_PIN_TWELVE || pin == PC_PIN_THIRTEEN))) begin
        r[i*MUX_PITCH +: MUX_W] = code;
      end
    end
    return r;
  endfunction

  assign mux_lo_wr = mux_merge(s_q.mux_lo, PWDATA, 0, EXT_FAST_OSC_IS_MAIN);
  assign mux_hi_wr = mux_merge(s_q.mux_hi, PWDATA, 8, EXT_FAST_OSC_IS_MAIN);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0]  sel;
    logic [1:0]  dcode;
    logic        od;
    s_d  = s_q;
    sel  = 3'h0;
    dcode = 2'h0;
    od   = 1'b0;
    s_d.ready  = 1'b0;
    s_d.slverr = 1'b0;
    s_d.idr    = PIN_IN;
    // interrupt events set status; set wins over a same-cycle clear
    if (wr_en && PREADY == 1'b0 && PADDR == OFS_IRQ_STAT) begin
      s_d.ist = s_q.ist & ~PWDATA;
    end
    s_d.ist = s_d.ist | {IRQ_EVENT & s_q.ien[31:16], IRQ_EVENT & s_q.ien[15:0]};
    // one-wait-state slave: answer in the second access cycle
    if (PSEL && PENABLE && !s_q.ready) begin
      s_d.ready  = 1'b1;
      s_d.slverr = !addr_ok;
      s_d.rdata  = 32'h0000_0000;
      if (wr_en && addr_ok) begin
        case (PADDR)
          OFS_MUX_LOW:   if (s_q.unlock) s_d.mux_lo = mux_lo_wr;
          OFS_MUX_HIGH:  if (s_q.unlock) s_d.mux_hi = mux_hi_wr;
          OFS_DIRECTION: if (s_q.unlock) s_d.dir = PWDATA;
          OFS_PULL:      if (s_q.unlock) s_d.pull = PWDATA;
          OFS_DEBOUNCE:  s_d.deb = PWDATA[15:0];
          OFS_STRENGTH:  s_d.str = PWDATA[15:0];
          OFS_IRQ_EN:    s_d.ien = PWDATA;
          OFS_IRQ_CTRL:  s_d.ictl = PWDATA;
          OFS_OUT_DATA:  s_d.odr = PWDATA[15:0];
          OFS_BIT_SETRST: s_d.odr = (s_q.odr | PWDATA[15:0]) & ~PWDATA[31:16];
          OFS_BIT_CLEAR: s_d.odr = s_q.odr & ~PWDATA[15:0];
          OFS_UNLOCK:    s_d.unlock = (PWDATA == UNLOCK_ACTIVE);
          default: s_d.odr = s_q.odr;
        endcase
      end
      if (rd_en && addr_ok) begin
        case (PADDR)
          OFS_MUX_LOW:   s_d.rdata = s_q.mux_lo & MUX_USED_MASK;
          OFS_MUX_HIGH:  s_d.rdata = s_q.mux_hi & MUX_USED_MASK;
          OFS_DIRECTION: s_d.rdata = s_q.dir;
          OFS_PULL:      s_d.rdata = s_q.pull;
          OFS_DEBOUNCE:  s_d.rdata = {16'h0000, s_q.deb};
          OFS_STRENGTH:  s_d.rdata = {16'h0000, s_q.str};
          OFS_IRQ_EN:    s_d.rdata = s_q.ien;
          OFS_IRQ_STAT:  s_d.rdata = s_q.ist;
          OFS_IRQ_CTRL:  s_d.rdata = s_q.ictl;
          OFS_OUT_DATA:  s_d.rdata = {16'h0000, s_q.odr};
          OFS_IN_DATA:   s_d.rdata = {16'h0000, s_q.idr};
          OFS_UNLOCK:    s_d.rdata = {31'h0, s_q.unlock};
          default:       s_d.rdata = 32'h0000_0000; // write-only reads zero
        endcase
      end
    end
    // pad drive per pin
    for (int p = 0; p < PINS; p++) begin
      sel   = (p < 8) ? s_q.mux_lo[p*MUX_PITCH +: MUX_W]
                      : s_q.mux_hi[(p%8)*MUX_PITCH +: MUX_W];
      dcode = s_q.dir[p*DIR_W +: DIR_W];
      if (sel == FUNC_ZERO) begin
        // register governs; 1x is input
        od = (dcode == DIR_OPEN_DRAIN);
        s_d.poe[p]  = !dcode[1] && (!od || !s_q.odr[p]);
        s_d.pout[p] = s_q.odr[p];
      end else begin
        // function owns direction; register ignored
        od = ALT_OPEN_DRAIN[p];
        s_d.poe[p]  = ALT_OE[p] && (!od || !ALT_OUT[p]);
        s_d.pout[p] = ALT_OUT[p];
      end
      // open-drain only pads never drive high
      if (IS_PORT_C && (p == 7 || p == 8)) begin
        s_d.poe[p] = s_d.poe[p] && !s_d.pout[p];
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      s_q        <= '0;
      s_q.mux_lo <= MUX_LO_INIT & MUX_USED_MASK;
      s_q.mux_hi <= RST_MUX_HIGH_P & MUX_USED_MASK;
      s_q.dir    <= RST_DIR_P;
      s_q.pull   <= RST_PULL_P;
      s_q.unlock <= 1'b0;
    end else if (CLK_EN) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign PRDATA  = s_q.rdata;
  assign PREADY  = s_q.ready;
  assign PSLVERR = s_q.slverr;
  assign PIN_OUT = s_q.pout;
  assign PIN_OE  = s_q.poe;
  assign PIN_FUNCTION_SELECT = {s_q.mux_hi[30:28], s_q.mux_hi[26:24], s_q.mux_hi[22:20],
                                s_q.mux_hi[18:16], s_q.mux_hi[14:12], s_q.mux_hi[10:8],
                                s_q.mux_hi[6:4], s_q.mux_hi[2:0],
                                s_q.mux_lo[30:28], s_q.mux_lo[26:24], s_q.mux_lo[22:20],
                                s_q.mux_lo[18:16], s_q.mux_lo[14:12], s_q.mux_lo[10:8],
                                s_q.mux_lo[6:4], s_q.mux_lo[2:0]};
  assign PULL_CTRL   = s_q.pull;
  assign DEBOUNCE_EN = s_q.deb;
  assign STRENGTH_EN = s_q.str;
  assign IRQ_ENABLE  = s_q.ien;
  assign IRQ_CONTROL = s_q.ictl;

endmodule // gpmx_port

`default_nettype wire

/* design/gpmx_pkg.sv */
/*
  gpmx_pkg: register map, field layout, reset values and codes for the
  general-purpose port mux/config block.
  assumes: 32-bit apb, one port instance per block, sixteen pins per port.
*/
package gpmx_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses within a port block)
  // ----------------------------------------------------------------
  localparam logic [12:0] OFS_MUX_LOW    = 13'h0000;
  localparam logic [12:0] OFS_MUX_HIGH   = 13'h0004;
  localparam logic [12:0] OFS_DIRECTION  = 13'h0008;
  localparam logic [12:0] OFS_PULL       = 13'h000C;
  localparam logic [12:0] OFS_DEBOUNCE   = 13'h0010;
  localparam logic [12:0] OFS_STRENGTH   = 13'h0014;
  localparam logic [12:0] OFS_IRQ_EN     = 13'h0020;
  localparam logic [12:0] OFS_IRQ_STAT   = 13'h0024;
  localparam logic [12:0] OFS_IRQ_CTRL   = 13'h0028;
  localparam logic [12:0] OFS_OUT_DATA   = 13'h0030;
  localparam logic [12:0] OFS_IN_DATA    = 13'h0034;
  localparam logic [12:0] OFS_BIT_SETRST = 13'h0038;
  localparam logic [12:0] OFS_BIT_CLEAR  = 13'h003C;
  localparam logic [12:0] OFS_UNLOCK     = 13'h1FF0;

  // ----------------------------------------------------------------
  // port bases and layout
  // ----------------------------------------------------------------
  localparam logic [31:0] PORT_A_BASE    = 32'h4000_1000;
  localparam logic [31:0] PORT_G_BASE    = 32'h4000_1600;
  localparam logic [31:0] PORT_STRIDE    = 32'h0000_0100;
  localparam int          PINS           = 16;
  localparam int          MUX_W          = 3;
  localparam int          MUX_PITCH      = 4;
  localparam int          DIR_W          = 2;
  localparam logic [31:0] MUX_USED_MASK  = 32'h7777_7777;
  localparam logic [15:0] DATA_MASK      = 16'hFFFF;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_MUX_LOW    = 32'h7777_7777;
  localparam logic [31:0] RST_MUX_HIGH   = 32'h7777_7777;
  localparam logic [31:0] RST_DIRECTION  = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_PULL       = 32'h0000_0000;
  localparam logic [31:0] RST_ZERO       = 32'h0000_0000;
  localparam logic [31:0] RST_PC_LOW_64  = 32'h7777_7733;
  localparam logic [31:0] RST_PC_LOW_48  = 32'h7777_7704;
  localparam logic [31:0] UNLOCK_ACTIVE  = 32'h0000_0001;

  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  localparam logic [2:0] FUNC_ZERO  = 3'h0;
  localparam logic [2:0] FUNC_FOUR  = 3'h4;
  localparam logic [2:0] FUNC_SEVEN = 3'h7;
  localparam logic [1:0] DIR_PUSH_PULL  = 2'h0;
  localparam logic [1:0] DIR_OPEN_DRAIN = 2'h1;
  localparam int PC_PIN_TWELVE   = 12;
  localparam int PC_PIN_THIRTEEN = 13;

  typedef enum logic [2:0] {
    GPMX_IDLE   = 3'b001,
    GPMX_SETUP  = 3'b010,
    GPMX_ACCESS = 3'b100
  } gpmx_bus_state_t;

endpackage : gpmx_pkg

/* verif/gpmx_port_sva.sv */
/* gpmx_port_sva: port-level checks of one mux/config port.
   assumes: bound to gpmx_port, one CORE_CLK domain, port C strap set. */
`timescale 1ns/10ps
`default_nettype none
module gpmx_port_sva
  import gpmx_pkg::*;
(
  // bus
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic        CLK_EN,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [12:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // pins and config
  input wire logic        EXT_FAST_OSC_IS_MAIN,
  input wire logic [15:0] PIN_OUT,
  input wire logic [15:0] PIN_OE,
  input wire logic [47:0] PIN_FUNCTION_SELECT
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  logic tk;
  logic wr;
  logic unl_q;
  assign tk = PSEL && PENABLE && !PREADY && CLK_EN;
  assign wr = tk && PWRITE;
  // gate copy sampled before the write lands, so lock checks see the old gate
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) unl_q <= 1'b0;
    else if (wr && PADDR == OFS_UNLOCK) unl_q <= (PWDATA == UNLOCK_ACTIVE);
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_READY_ONE_PULSE:
    assert property (tk |=> PREADY ##1 !PREADY) else $error("ready not a single pulse");
  AST_ERR_WITH_READY:
    assert property (PSLVERR |-> PREADY && (PWRITE || PRDATA == 32'h0))
    else $error("error answer malformed");
  AST_LOCKED_MUX_LOW:
    assert property (wr && !unl_q && PADDR == OFS_MUX_LOW |=> $stable(PIN_FUNCTION_SELECT[23:0]))
    else $error("locked mux low changed");
  AST_LOW_FIELD:
    assert property (wr && unl_q && PADDR == OFS_MUX_LOW && !(PWDATA[2:0] inside {3'h5, 3'h6})
      |=> PIN_FUNCTION_SELECT[2:0] == $past(PWDATA[2:0])) else $error("pin0 field wrong");
  AST_HIGH_FIELD:
    assert property (wr && unl_q && PADDR == OFS_MUX_HIGH && !(PWDATA[2:0] inside {3'h5, 3'h6})
      |=> PIN_FUNCTION_SELECT[26:24] == $past(PWDATA[2:0])) else $error("pin8 field wrong");
  AST_RSVD_CODE_KEEPS:
    assert property (wr && unl_q && PADDR == OFS_MUX_LOW && PWDATA[2:0] inside {3'h5, 3'h6}
      |=> $stable(PIN_FUNCTION_SELECT[2:0])) else $error("reserved code taken");
  AST_OSC_LOCK:
    assert property (wr && PADDR == OFS_MUX_HIGH && EXT_FAST_OSC_IS_MAIN
      |=> $stable(PIN_FUNCTION_SELECT[41:36])) else $error("pins 12/13 changed");
  AST_PC_OPEN_DRAIN:
    assert property ((PIN_OE[8:7] & PIN_OUT[8:7]) == 2'h0) else $error("pin 7/8 drove high");
  AST_RSVD_BITS_ZERO:
    assert property (PREADY && !PWRITE && PADDR == OFS_MUX_LOW |-> (PRDATA & ~MUX_USED_MASK) == 32'h0)
    else $error("reserved mux bits set");
  COV_MUX_WRITE: cover property (wr && unl_q && PADDR == OFS_MUX_LOW);
  COV_OSC_LOCK: cover property (wr && EXT_FAST_OSC_IS_MAIN && PADDR == OFS_MUX_HIGH);
  COV_SLVERR: cover property (PSLVERR);
endmodule // gpmx_port_sva
bind gpmx_port gpmx_port_sva gpmx_port_sva_inst (.CORE_CLK(CORE_CLK), .RST(RST), .CLK_EN(CLK_EN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .EXT_FAST_OSC_IS_MAIN(EXT_FAST_OSC_IS_MAIN),
  .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PIN_FUNCTION_SELECT(PIN_FUNCTION_SELECT));
`default_nettype wire

/* verif/gpmx_pins_model.sv */
/* gpmx_pins_model: board pads with pull-ups and the on-chip peripherals.
   assumes: one peripheral (pin 2) drives, low and push-pull. */
`timescale 1ns/10ps
`default_nettype none
module gpmx_pins_model (
  // pad side
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  output logic      [15:0] pin_in,
  // alternate functions
  output logic      [15:0] alt_out,
  output logic      [15:0] alt_oe,
  output logic      [15:0] alt_od
);
  // ------------------------------------------------------------
  // pads
  // ------------------------------------------------------------
  // released pads float up to the external pull-up, never the last value
  assign pin_in  = (pin_oe & pin_out) | ~pin_oe;
  assign alt_oe  = 16'h0004;
  assign alt_out = 16'h0000;
  assign alt_od  = 16'h0000;
endmodule // gpmx_pins_model
`default_nettype wire

/* verif/testbench.sv */
/* testbench: register, gate, lock and pad tests of one port C instance.
   assumes: gpmx_port with the 64-pin strap, pads modelled by gpmx_pins_model. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import gpmx_pkg::*;
  typedef struct packed {logic [12:0] a; logic [31:0] v;} gpmx_row_t;
  logic clk, rst, clk_en, psel, penable, pwrite, pready, pslverr, osc;
  logic [12:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] pin_in, pin_out, pin_oe, alt_out, alt_oe, alt_od, irq_ev;
  logic [47:0] pfs;
  logic [31:0] pull_o, ien_o, ictl_o;
  logic [15:0] deb_o, str_o;
  int mismatches = 0;
  int n_compared = 0;
  gpmx_row_t rows[13] = '{'{OFS_MUX_LOW, 32'h7777_7733}, '{OFS_MUX_HIGH, 32'h7777_7777},
    '{OFS_DIRECTION, 32'hFFFF_FFFF}, '{OFS_PULL, 32'h0}, '{OFS_DEBOUNCE, 32'h0},
    '{OFS_STRENGTH, 32'h0}, '{OFS_IRQ_EN, 32'h0}, '{OFS_IRQ_STAT, 32'h0}, '{OFS_IRQ_CTRL, 32'h0},
    '{OFS_OUT_DATA, 32'h0}, '{OFS_BIT_SETRST, 32'h0}, '{OFS_BIT_CLEAR, 32'h0}, '{OFS_UNLOCK, 32'h0}};
  gpmx_port #(.IS_PORT_C(1'b1), .PKG_64(1'b1)) gpmx_port_inst (.CORE_CLK(clk), .RST(rst),
    .CLK_EN(clk_en), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_FAST_OSC_IS_MAIN(osc), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .ALT_OUT(alt_out), .ALT_OE(alt_oe), .ALT_OPEN_DRAIN(alt_od), .IRQ_EVENT(irq_ev),
    .PIN_FUNCTION_SELECT(pfs), .PULL_CTRL(pull_o), .DEBOUNCE_EN(deb_o), .STRENGTH_EN(str_o),
    .IRQ_ENABLE(ien_o), .IRQ_CONTROL(ictl_o));
  gpmx_pins_model gpmx_pins_model_inst (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
    .alt_out(alt_out), .alt_oe(alt_oe), .alt_od(alt_od));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk); psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk); penable <= 1'b1;
    // no cycle limit here: only the watchdog ends a wait
    do begin @(posedge clk); end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rd(input logic [12:0] a, input logic [31:0] v, input string nm);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, v, r);
  endtask
  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin clk = 1'b0; forever #12.5 clk = ~clk; end
  initial begin repeat (5000) @(posedge clk); mismatches++; close_out; end
  initial begin
    logic [31:0] r;
    logic e;
    rst = 1'b1; clk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 13'h0; pwdata = 32'h0; osc = 1'b0; irq_ev = 16'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) rd(rows[i].a, rows[i].v, "reset value");
    $display("test reset values done");
    wr(OFS_MUX_LOW, 32'h0);
    wr(OFS_DIRECTION, 32'h0);
    rd(OFS_MUX_LOW, 32'h7777_7733, "locked mux");
    rd(OFS_DIRECTION, 32'hFFFF_FFFF, "locked dir");
    wr(OFS_UNLOCK, 32'h1);
    wr(OFS_MUX_LOW, 32'hF654_3218);
    rd(OFS_MUX_LOW, 32'h7774_3210, "mux low");
    chk("pin2 select", 32'h2, {29'h0, pfs[8:6]});
    osc <= 1'b1;
    wr(OFS_MUX_HIGH, 32'h0);
    rd(OFS_MUX_HIGH, 32'h0077_0000, "osc lock");
    osc <= 1'b0;
    wr(OFS_MUX_HIGH, 32'h0);
    rd(OFS_MUX_HIGH, 32'h0, "mux high");
    $display("test mux done");
    wr(OFS_MUX_LOW, 32'h0774_3200);
    wr(OFS_DIRECTION, 32'hFFFF_3FF4);
    rd(OFS_DIRECTION, 32'hFFFF_3FF4, "direction");
    wr(OFS_OUT_DATA, 32'h83);
    repeat (2) @(posedge clk);
    chk("pad oe high data", 32'h5, {16'h0, pin_oe});
    chk("pad out", 32'h1, {31'h0, pin_out[0]});
    wr(OFS_OUT_DATA, 32'h0);
    repeat (2) @(posedge clk);
    chk("pad oe low data", 32'h87, {16'h0, pin_oe});
    rd(OFS_IN_DATA, 32'h0000_FF78, "input data");
    wr(OFS_IN_DATA, 32'h0);
    rd(OFS_IN_DATA, 32'h0000_FF78, "input read only");
    wr(OFS_MUX_LOW, 32'h0774_3207);
    wr(OFS_DIRECTION, 32'hFFFF_3FF6);
    repeat (2) @(posedge clk);
    chk("analog pad oe", 32'h0, {31'h0, pin_oe[0]});
    $display("test pads done");
    wr(OFS_BIT_SETRST, 32'h3);
    rd(OFS_OUT_DATA, 32'h3, "bit set");
    wr(OFS_BIT_CLEAR, 32'h1);
    rd(OFS_OUT_DATA, 32'h2, "bit clear");
    wr(OFS_BIT_SETRST, 32'h0002_0001);
    rd(OFS_OUT_DATA, 32'h1, "set and clear");
    rd(OFS_BIT_SETRST, 32'h0, "write only");
    wr(OFS_IRQ_EN, 32'h0001_0001);
    irq_ev <= 16'h1;
    @(posedge clk) irq_ev <= 16'h0;
    rd(OFS_IRQ_STAT, 32'h0001_0001, "irq set");
    wr(OFS_IRQ_STAT, 32'h0001_0001);
    rd(OFS_IRQ_STAT, 32'h0, "irq clear");
    apb(1'b0, 13'h0018, 32'h0, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    wr(OFS_PULL, 32'h0000_000A);
    wr(OFS_DEBOUNCE, 32'hFFFF_A5A5);
    wr(OFS_STRENGTH, 32'h0000_5A5A);
    wr(OFS_IRQ_CTRL, 32'h1234_5678);
    wr(OFS_UNLOCK, 32'h2);
    rd(OFS_UNLOCK, 32'h0, "relock");
    wr(OFS_PULL, 32'h5);
    rd(OFS_PULL, 32'hA, "locked pull");
    rd(OFS_DEBOUNCE, 32'h0000_A5A5, "debounce");
    chk("pull out", 32'hA, pull_o);
    chk("debounce out", 32'hA5A5, {16'h0, deb_o});
    chk("strength out", 32'h5A5A, {16'h0, str_o});
    chk("irq enable out", 32'h0001_0001, ien_o);
    chk("irq control out", 32'h1234_5678, ictl_o);
    $display("test bits irq gate done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_MUX_LOW, 32'h7777_7733, "mux after reset");
    rd(OFS_DIRECTION, 32'hFFFF_FFFF, "dir after reset");
    rd(OFS_UNLOCK, 32'h0, "gate after reset");
    chk("pad oe after reset", 32'h4, {16'h0, pin_oe});
    $display("test mid-run reset done");
    close_out;
  end
endmodule // testbench
`default_nettype wire
